// [verilog/nest_irq_ctrl.sv]
/*
 * Nested priority interrupt controller for an 8-bit core: arbitration,
 * pending latches, entry sequence, return, wake-up and AXI4-Lite registers.
 * Assumes the core, peripherals and register master share aclk; only the
 * external pins are asynchronous.
 */
// What this block does
// - Entry starts only when the running instruction reports completion.
// - Entry to maskable or trap routine pulses a stack push of core registers.
// - Maskable entry loads current priority bits with the serviced vector's programmed code.
// - After stacking, vector address is loaded so the routine's fetch begins.
// - Interrupt return restores the popped priority bits, resuming previous level.
// - Priority codes: 10 level 0, 01 level 1, 00 level 2, 11 level 3.
// - Highest software priority wins; ties go to lowest vector number.
// - Unserviced edge and peripheral requests stay latched until they win or their flag is cleared.
// - Reset and trap outrank every maskable request in arbitration.
// - Non-maskable entry ignores mask, forces level 3, stacks except reset, ends Halt.
// - Executing trap raises a trap request served by the normal entry.
// - First routine after reset runs at level 3 from the reset vector.
// - Maskable request served only if enabled and strictly above current level.
// - External lines wake Halt; their sensitivity is set by a sense register.
// - Edge external requests are latched and cleared on routine entry.
// - Selected pins of one group are ORed onto their shared line.
// - Peripheral requests need both the status flag and its enable bit.
// - A flag-clearing sequence drops the request latch, even if pending.
// - Any request ends Wait; only Halt-capable ones end Halt.
// - After Halt, the first serviced request is chosen among Halt-capable ones.
// - Concurrent mode lets only a trap preempt a routine; nested mode lets higher preempt.
// - Nesting depth wraps silently; no stack overflow is reported.
// - Writing the level-0 code to a priority field leaves that field unchanged.
// - Vectors sit between FFE0h and FFFFh, ordered by hardware priority.
`timescale 1ns/1ps

module nest_irq_ctrl
  import nest_irq_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [5:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [5:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Core side
  input  wire logic        instr_end,
  input  wire logic        trap_exec,
  input  wire logic        interrupt_return_instruction_exec,
  input  wire logic [1:0]  popped_code,
  input  wire logic        code_we,
  input  wire logic [1:0]  code_wdata,
  input  wire logic        halt_mode,
  input  wire logic        wait_mode,
  output logic             entry_start,
  output logic             push_stack,
  output logic             load_vector,
  output service_t         service,
  output logic [1:0]       cur_code,
  output logic             wake,
  // Sources
  input  wire logic [8:0]  ext_pins,
  input  wire logic [12:0] periph_flag,
  input  wire logic [12:0] flag_clear
);

  logic [25:0] prio;
  logic [5:0]  sense;
  logic [8:0]  pin_sel;
  logic [12:0] periph_en;
  logic        nested_mode;
  logic [8:0]  pin_meta;
  logic [8:0]  pin_sync;
  logic [2:0]  line_prev;
  logic [2:0]  line_now;
  logic [12:0] pend_latch;
  logic [12:0] pending;
  logic [12:0] req_set;
  logic [12:0] entry_clr;
  logic        trap_pend;
  logic        from_halt;
  logic        entry_done;
  logic [3:0]  depth;
  seq_state_t  state;
  logic        sel_nmi;
  logic [3:0]  sel_vec;
  logic        win_valid;
  logic [3:0]  win_vec;
  logic [1:0]  win_lvl;
  logic        wr_fire;
  logic        rd_fire;
  logic [31:0] next_rdata;
  logic        next_rerr;

  // ----------------------------------------------------------------
  // External pins
  // ----------------------------------------------------------------

  // Two-stage synchroniser; only the second stage is used
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= ext_pins;
      pin_sync <= pin_meta;
    end
  end

  // Group OR of the selected pins onto each line
  always_comb begin
    for (int e = 0; e < NUM_EXT; e++) begin
      line_now[e] = |(pin_sync[e*GRP_PINS +: GRP_PINS] &
                      pin_sel[e*GRP_PINS +: GRP_PINS]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) line_prev <= '0;
    else          line_prev <= line_now;
  end

  // ----------------------------------------------------------------
  // Pending latches, one per vector
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_VEC; i++) begin : g_pend
    if (i >= EXT_FIRST && i < EXT_FIRST + NUM_EXT) begin : g_ext
      localparam int E = i - EXT_FIRST;
      logic [1:0] s;
      assign s = sense[2*E +: 2];
      // Edge modes latch; level mode follows the line
      assign req_set[i] = (s == SENSE_FALL) ? (line_prev[E] & ~line_now[E]) :
                          (s == SENSE_RISE) ? (~line_prev[E] & line_now[E]) :
                          (s == SENSE_HIGH) ? 1'b0 :
                          (line_prev[E] ^ line_now[E]);
      assign pending[i] = (s == SENSE_HIGH) ? line_now[E] : pend_latch[i];
    end else begin : g_per
      assign req_set[i] = periph_flag[i] & periph_en[i] &
                          VEC_PRESENT[i];
      assign pending[i] = pend_latch[i];
    end
    // A new request in the clearing cycle survives
    always_ff @(posedge aclk) begin
      if (!aresetn) pend_latch[i] <= 1'b0;
      else          pend_latch[i] <= req_set[i] |
                                     (pend_latch[i] & ~flag_clear[i] &
                                      ~entry_clr[i]);
    end
  end

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------

  // Scan downwards so that on equal level the lower number wins
  always_comb begin
    win_valid = 1'b0;
    win_vec   = '0;
    win_lvl   = '0;
    for (int i = NUM_VEC - 1; i >= 0; i--) begin
      if (pending[i] &&
          code_level(prio[2*i +: 2]) > code_level(cur_code) &&
          (nested_mode || depth == '0) &&
          (!(halt_mode || from_halt) || HALT_CAPABLE[i]) &&
          (!win_valid || code_level(prio[2*i +: 2]) >= win_lvl)) begin
        win_valid = 1'b1;
        win_vec   = 4'(i);
        win_lvl   = code_level(prio[2*i +: 2]);
      end
    end
  end

  // Trap raised by the core, dropped when its routine is entered
  always_ff @(posedge aclk) begin
    if (!aresetn) trap_pend <= 1'b0;
    else          trap_pend <= trap_exec |
                               (trap_pend &
                                !(state == ST_LOAD && sel_nmi));
  end

  // ----------------------------------------------------------------
  // Entry sequence
  // ----------------------------------------------------------------

  // Reset enters its routine first; others wait for instruction end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state   <= ST_RESET;
      sel_nmi <= 1'b1;
      sel_vec <= '0;
    end else begin
      case (state)
        ST_RESET: state <= ST_LOAD;
        ST_IDLE: begin
          if (instr_end && (trap_pend || win_valid)) begin
            state   <= ST_STACK;
            sel_nmi <= trap_pend;
            sel_vec <= win_vec;
          end
        end
        ST_STACK: state <= ST_LOAD;
        ST_LOAD:  state <= ST_IDLE;
        default:  state <= ST_IDLE;
      endcase
    end
  end

  assign entry_clr = (state == ST_LOAD && !sel_nmi) ?
                     (13'h0001 << sel_vec) : '0;

  // Core strobes and the vector handed to the core
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      entry_start <= 1'b0;
      push_stack  <= 1'b0;
      load_vector <= 1'b0;
      service     <= '0;
    end else begin
      entry_start <= state == ST_IDLE && instr_end &&
                     (trap_pend || win_valid);
      push_stack  <= state == ST_STACK;
      load_vector <= state == ST_LOAD;
      if (state == ST_RESET) begin
        service <= '{vector: VEC_RESET, code: CODE_L3};
      end else if (state == ST_STACK) begin
        service.vector <= sel_nmi ? VEC_TRAP :
                          VEC_BASE - {11'h000, sel_vec, 1'b0};
        service.code   <= sel_nmi ? CODE_L3 : prio[2*sel_vec +: 2];
      end
    end
  end

  // Current priority bits of the condition code register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_code <= CODE_L3;
    end else if (state == ST_RESET) begin
      cur_code <= CODE_L3;
    end else if (state == ST_LOAD) begin
      cur_code <= sel_nmi ? CODE_L3 : prio[2*sel_vec +: 2];
    end else if (interrupt_return_instruction_exec) begin
      cur_code <= popped_code;
    end else if (code_we) begin
      cur_code <= code_wdata;
    end
  end

  // Reset entry starts the main program, so it opens no nesting level;
  // counting it would lock out every maskable request in concurrent mode
  assign entry_done = state == ST_LOAD && service.vector != VEC_RESET;

  // Depth of running routines; wraps with no overflow report
  always_ff @(posedge aclk) begin
    if (!aresetn)                      depth <= '0;
    else if (entry_done && !interrupt_return_instruction_exec) depth <= depth + 4'h1;
    else if (interrupt_return_instruction_exec && !entry_done) depth <= depth - 4'h1;
  end

  // ----------------------------------------------------------------
  // Wake-up
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake      <= 1'b0;
      from_halt <= 1'b0;
    end else begin
      wake <= (wait_mode && (|pending || trap_pend)) ||
              (halt_mode && (|(pending & HALT_CAPABLE) || trap_pend));
      if (halt_mode)
        from_halt <= 1'b1;
      else if (state == ST_LOAD)
        from_halt <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign wr_fire = awvalid && awready && wvalid && wready;
  assign rd_fire = arvalid && arready;

  // Address and data are taken together, one write in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else begin
      awready <= awvalid && wvalid && !awready && !bvalid;
      wready  <= awvalid && wvalid && !awready && !bvalid;
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= (awaddr > OFS_PEN || awaddr == OFS_STATUS) ?
                  RESP_SLVERR : RESP_OKAY;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Priority fields; the level-0 code is refused field by field
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prio <= PRIO_RST;
    end else if (wr_fire && wstrb[0] && awaddr <= OFS_PRIO3) begin
      for (int j = 0; j < 4; j++) begin
        if (4 * int'(awaddr[3:2]) + j < NUM_VEC &&
            wdata[2*j +: 2] != CODE_L0)
          prio[2*(4*awaddr[3:2] + j) +: 2] <= wdata[2*j +: 2];
      end
    end
  end

  // Sense, pin selection, mode and peripheral enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sense       <= SENSE_RST;
      pin_sel     <= PINSEL_RST;
      nested_mode <= 1'b1;
      periph_en   <= PEN_RST;
    end else if (wr_fire) begin
      case (awaddr)
        OFS_SENSE:  sense       <= wdata[5:0];
        OFS_PINSEL: pin_sel     <= wdata[8:0];
        OFS_CTRL:   nested_mode <= wdata[0];
        OFS_PEN:    periph_en   <= wdata[12:0];
        default:    nested_mode <= nested_mode;
      endcase
    end
  end

  // Read data selection
  always_comb begin
    next_rdata = '0;
    next_rerr  = 1'b0;
    case (araddr)
      OFS_PRIO0:   next_rdata = {24'h0, prio[7:0]};
      6'h04:       next_rdata = {24'h0, prio[15:8]};
      6'h08:       next_rdata = {24'h0, prio[23:16]};
      OFS_PRIO3:   next_rdata = {24'h0, 6'h3F, prio[25:24]};
      OFS_SENSE:   next_rdata = {26'h0, sense};
      OFS_PINSEL:  next_rdata = {23'h0, pin_sel};
      OFS_STATUS:  next_rdata = {depth, trap_pend, pending, 12'h0,
                                 cur_code};
      OFS_CTRL:    next_rdata = {31'h0, nested_mode};
      OFS_PEN:     next_rdata = {19'h0, periph_en};
      default:     next_rerr  = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else begin
      arready <= arvalid && !arready && !rvalid;
      if (rd_fire) begin
        rvalid <= 1'b1;
        rdata  <= next_rdata;
        rresp  <= next_rerr ? RESP_SLVERR : RESP_OKAY;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_entry;
    push_stack ##1 load_vector;
  endsequence

  a_entry_at_end: assert property (@(posedge aclk) disable iff (!aresetn)
    entry_start |-> $past(instr_end))
    else $error("entry began inside an instruction");

  a_stack_then_load: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(push_stack) |-> s_entry)
    else $error("vector not loaded right after stacking");

  a_start_to_load: assert property (@(posedge aclk) disable iff (!aresetn)
    entry_start |=> s_entry)
    else $error("entry did not stack and load");

  a_level_loaded: assert property (@(posedge aclk) disable iff (!aresetn)
    load_vector |-> cur_code == service.code)
    else $error("priority bits differ from serviced code");

  a_nmi_level3: assert property (@(posedge aclk) disable iff (!aresetn)
    load_vector && service.vector >= VEC_TRAP |-> cur_code == CODE_L3)
    else $error("non-maskable entry not at level 3");

  a_interrupt_return_instruction_restore: assert property (@(posedge aclk) disable iff (!aresetn)
    interrupt_return_instruction_exec && state == ST_IDLE |=> cur_code == $past(popped_code))
    else $error("return did not restore priority");

  a_vector_range: assert property (@(posedge aclk) disable iff (!aresetn)
    load_vector |-> service.vector >= VEC_FLOOR)
    else $error("vector outside the top table");

  a_reset_first: assert property (@(posedge aclk) disable iff (!aresetn)
    state == ST_RESET |=> ##1 load_vector && !push_stack &&
                              service.vector == VEC_RESET)
    else $error("reset entry wrong");

  a_no_level0: assert property (@(posedge aclk) disable iff (!aresetn)
    prio[1:0] != CODE_L0 && prio[25:24] != CODE_L0)
    else $error("level-0 code stored");

  // Served code against the level that held at the deciding edge
  a_mask_win: assert property (@(posedge aclk) disable iff (!aresetn)
    load_vector && service.vector <= VEC_BASE |->
      code_level(service.code) > code_level($past(cur_code, 3)))
    else $error("maskable entry not above previous level");

endmodule

// [verilog/nest_irq_pkg.sv]
/*
 * Constants, types and helpers of the nested interrupt controller.
 * Assumes a single 25 MHz clock domain and an AXI4-Lite register bus.
 */
package nest_irq_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_VEC   = 13;
  localparam int NUM_EXT   = 3;
  localparam int GRP_PINS  = 3;
  localparam int EXT_FIRST = 2;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_PRIO0   = 6'h00;
  localparam logic [5:0] OFS_PRIO3   = 6'h0C;
  localparam logic [5:0] OFS_SENSE   = 6'h10;
  localparam logic [5:0] OFS_PINSEL  = 6'h14;
  localparam logic [5:0] OFS_STATUS  = 6'h18;
  localparam logic [5:0] OFS_CTRL    = 6'h1C;
  localparam logic [5:0] OFS_PEN     = 6'h20;

  // Reset values
  localparam logic [25:0] PRIO_RST   = 26'h3FFFFFF;
  localparam logic [5:0]  SENSE_RST  = 6'h00;
  localparam logic [8:0]  PINSEL_RST = 9'h000;
  localparam logic [12:0] PEN_RST    = 13'h0000;

  // Priority codes held in the condition code register bits
  localparam logic [1:0] CODE_L0 = 2'h2;
  localparam logic [1:0] CODE_L1 = 2'h1;
  localparam logic [1:0] CODE_L2 = 2'h0;
  localparam logic [1:0] CODE_L3 = 2'h3;

  // Sense encodings per external line
  localparam logic [1:0] SENSE_HIGH = 2'h0;
  localparam logic [1:0] SENSE_FALL = 2'h1;
  localparam logic [1:0] SENSE_RISE = 2'h2;

  // Vector addresses, fixed at the top of memory
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP  = 16'hFFFC;
  localparam logic [15:0] VEC_BASE  = 16'hFFFA;
  localparam logic [15:0] VEC_FLOOR = 16'hFFE0;

  // Vectors that may end Halt; vector 1 is reserved
  localparam logic [12:0] HALT_CAPABLE = 13'h041D;
  localparam logic [12:0] VEC_PRESENT  = 13'h1FFD;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_IDLE  = 2'b01,
    ST_STACK = 2'b10,
    ST_LOAD  = 2'b11
  } seq_state_t;

  // What the core receives when it enters a routine
  typedef struct packed {
    logic [15:0] vector;
    logic [1:0]  code;
  } service_t;

  // Maps a two-bit priority code onto its ordered level 0..3
  function automatic logic [1:0] code_level(input logic [1:0] code);
    case (code)
      CODE_L0: code_level = 2'h0;
      CODE_L1: code_level = 2'h1;
      CODE_L2: code_level = 2'h2;
      default: code_level = 2'h3;
    endcase
  endfunction

endpackage

// [tb/core_model.sv]
/*
 * Behavioural model of the core beside the interrupt controller: ends an
 * instruction every other cycle and keeps the stacked priority bits.
 * Assumes one shared clock and the controller's one-cycle entry strobes.
 */
`timescale 1ns/1ps

module core_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       push_stack,
  input  wire logic [1:0] cur_code,
  input  wire logic       ret_req,
  output logic            instr_end,
  output logic            interrupt_return_instruction_exec,
  output logic [1:0]      popped_code
);
  logic [1:0] stk[$];

  // Instruction boundary every other cycle, so entry has to wait for it
  always @(posedge aclk) begin
    if (!aresetn) begin
      instr_end <= 1'b0;
    end else begin
      instr_end <= ~instr_end;
    end
  end

  // Saved priority bits; the popped lines toggle when not in use
  always @(posedge aclk) begin
    interrupt_return_instruction_exec   <= 1'b0;
    popped_code <= ~popped_code;
    if (!aresetn) begin
      stk.delete();
      popped_code <= 2'h0;
    end else if (push_stack) begin
      stk.push_back(cur_code);
    end else if (ret_req && stk.size() > 0) begin
      interrupt_return_instruction_exec   <= 1'b1;
      popped_code <= stk.pop_back();
    end
  end
endmodule

// [tb/tb.sv]
/*
 * Self-checking bench of the nested interrupt controller.
 * Assumes the core model beside it and a 25 MHz clock.
 */
`timescale 1ns/1ps

module tb
  import nest_irq_pkg::*;
  ;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [5:0]  awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        trap_exec, code_we, halt_mode, wait_mode, ret_req;
  logic [1:0]  code_wdata;
  logic [8:0]  ext_pins;
  logic [12:0] periph_flag, flag_clear;
  wire logic   awready, wready, bvalid, arready, rvalid;
  wire logic   [1:0] bresp, rresp, popped_code, cur_code;
  wire logic   [31:0] rdata;
  wire logic   instr_end, interrupt_return_instruction_exec, entry_start, push_stack, load_vector;
  wire logic   wake;
  service_t    service;
  int          n_mismatch, n_checks;

  nest_irq_ctrl dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .instr_end(instr_end), .trap_exec(trap_exec),
    .interrupt_return_instruction_exec(interrupt_return_instruction_exec), .popped_code(popped_code), .code_we(code_we),
    .code_wdata(code_wdata), .halt_mode(halt_mode),
    .wait_mode(wait_mode), .entry_start(entry_start),
    .push_stack(push_stack), .load_vector(load_vector),
    .service(service), .cur_code(cur_code), .wake(wake),
    .ext_pins(ext_pins), .periph_flag(periph_flag),
    .flag_clear(flag_clear));

  core_model core (.aclk(aclk), .aresetn(aresetn),
    .push_stack(push_stack), .cur_code(cur_code), .ret_req(ret_req),
    .instr_end(instr_end), .interrupt_return_instruction_exec(interrupt_return_instruction_exec),
    .popped_code(popped_code));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One AXI4-Lite transfer; ready is sampled at the falling edge so the
  // release lands right after the rising edge that took the item
  task automatic bus(input bit wr, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic [1:0] r);
    logic ta, tw, done;
    int   n;
    done = 1'b0;
    @(posedge aclk);
    if (wr) begin
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
    end else begin
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
    end
    for (n = 0; n < 50 && !done; n++) begin
      @(negedge aclk);
      ta   = wr ? awvalid & awready : arvalid & arready;
      tw   = wvalid & wready;
      done = wr ? bvalid : rvalid;
      q    = rdata;
      r    = wr ? bresp : rresp;
      @(posedge aclk);
      if (ta) begin
        awvalid <= 1'b0;
        arvalid <= 1'b0;
      end
      if (tw) wvalid <= 1'b0;
      if (done) begin
        bready <= 1'b0;
        rready <= 1'b0;
      end
    end
    if (!done) begin
      chk("bus answer", 32'h0, 32'h1);
      test_done;
    end
  endtask

  task automatic set_code(input logic [1:0] c);
    @(posedge aclk);
    code_we    <= 1'b1;
    code_wdata <= c;
    @(posedge aclk);
    code_we    <= 1'b0;
  endtask

  task automatic clr(input int v);
    @(posedge aclk);
    periph_flag[v] <= 1'b0;
    flag_clear[v]  <= 1'b1;
    @(posedge aclk);
    flag_clear[v]  <= 1'b0;
  endtask

  task automatic ret;
    @(posedge aclk);
    ret_req <= 1'b1;
    @(posedge aclk);
    ret_req <= 1'b0;
  endtask

  // Entry walk: start, then push, then vector load with new level
  task automatic expect_entry(input logic [15:0] vec,
                              input logic [1:0] code, input logic push);
    logic seen;
    int   n;
    seen = 1'b0;
    // Also catches a strobe launched at the caller's last edge
    for (n = 0; n < 40 && !seen; n++) begin
      #1 seen = entry_start;
      if (!seen) @(posedge aclk);
    end
    if (!seen) begin
      chk("entry start", 32'h0, 32'h1);
      test_done;
    end
    @(posedge aclk);
    #1 chk("push", 32'(push_stack), 32'(push));
    @(posedge aclk);
    #1 chk("load", 32'(load_vector), 32'h1);
    chk("vector", 32'(service.vector), 32'(vec));
    chk("code", 32'(service.code), 32'(code));
    chk("level", 32'(cur_code), 32'(code));
  endtask

  task automatic no_entry(input int cyc);
    logic seen;
    seen = 1'b0;
    repeat (cyc) begin
      @(posedge aclk);
      #1 seen = seen | entry_start;
    end
    chk("no entry", 32'(seen), 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] q;
    logic [1:0]  r;
    no_entry(2);
    chk("reset vector", 32'(service.vector), 32'(VEC_RESET));
    chk("reset code", 32'(service.code), 32'(CODE_L3));
    bus(0, OFS_PRIO0, 32'h0, q, r);
    chk("prio0 reset", q, 32'h000000FF);
    bus(0, OFS_PRIO3, 32'h0, q, r);
    chk("prio3 reset", q, 32'h000000FF);
    bus(1, OFS_PRIO0, 32'h000000CF, q, r);
    bus(1, OFS_PRIO0, 32'h00000064, q, r);
    bus(0, OFS_PRIO0, 32'h0, q, r);
    chk("level0 write kept", q, 32'h00000044);
    bus(0, 6'h3C, 32'h0, q, r);
    chk("unmapped resp", 32'(r), 32'(RESP_SLVERR));
    bus(1, OFS_STATUS, 32'h0, q, r);
    chk("status write resp", 32'(r), 32'(RESP_SLVERR));
    $display("test reset and registers ended");
  endtask

  task automatic t_periph;
    logic [31:0] q;
    logic [1:0]  r;
    bus(1, OFS_PEN, 32'h00000060, q, r);
    bus(1, 6'h04, 32'h000000D7, q, r);
    set_code(CODE_L0);
    @(posedge aclk);
    periph_flag[5] <= 1'b1;
    periph_flag[6] <= 1'b1;
    expect_entry(VEC_BASE - 16'h000A, CODE_L1, 1'b1);
    no_entry(12);
    bus(0, OFS_STATUS, 32'h0, q, r);
    chk("held pending", 32'(q[20]), 32'h1);
    clr(5);
    ret;
    expect_entry(VEC_BASE - 16'h000C, CODE_L1, 1'b1);
    $display("test peripheral arbitration ended");
  endtask

  task automatic t_clear;
    logic [31:0] q;
    logic [1:0]  r;
    clr(6);
    @(posedge aclk);
    periph_flag[6] <= 1'b1;
    periph_flag[7] <= 1'b1;
    no_entry(8);
    bus(0, OFS_STATUS, 32'h0, q, r);
    chk("pending again", 32'(q[20]), 32'h1);
    clr(6);
    bus(0, OFS_STATUS, 32'h0, q, r);
    chk("pending dropped", 32'(q[20]), 32'h0);
    ret;
    no_entry(12);
    chk("level restored", 32'(cur_code), 32'(CODE_L0));
    periph_flag[7] <= 1'b0;
    $display("test flag clearing ended");
  endtask

  task automatic t_trap;
    set_code(CODE_L3);
    @(posedge aclk);
    trap_exec <= 1'b1;
    @(posedge aclk);
    trap_exec <= 1'b0;
    expect_entry(VEC_TRAP, CODE_L3, 1'b1);
    ret;
    $display("test trap ended");
  endtask

  // Edge line wakes Halt; concurrent mode holds off, nested preempts
  task automatic t_ext;
    logic [31:0] q;
    logic [1:0]  r;
    bus(1, OFS_CTRL, 32'h00000000, q, r);
    bus(1, OFS_SENSE, 32'h00000002, q, r);
    bus(1, OFS_PINSEL, 32'h00000002, q, r);
    bus(1, OFS_PEN, 32'h000000E0, q, r);
    @(posedge aclk);
    halt_mode      <= 1'b1;
    periph_flag[7] <= 1'b1;
    no_entry(4);
    chk("halt no wake", 32'(wake), 32'h0);
    ext_pins[1] <= 1'b1;
    no_entry(8);
    chk("halt wake", 32'(wake), 32'h1);
    halt_mode <= 1'b0;
    set_code(CODE_L0);
    expect_entry(VEC_BASE - 16'h0004, CODE_L2, 1'b1);
    no_entry(8);
    bus(0, OFS_STATUS, 32'h0, q, r);
    chk("edge cleared", 32'(q[16]), 32'h0);
    bus(1, OFS_CTRL, 32'h00000001, q, r);
    expect_entry(VEC_BASE - 16'h000E, CODE_L3, 1'b1);
    clr(7);
    ret;
    ret;
    no_entry(4);
    chk("nest unwound", 32'(cur_code), 32'(CODE_L0));
    ext_pins[1] <= 1'b0;
    $display("test external and halt ended");
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {trap_exec, code_we, halt_mode, wait_mode, ret_req} = '0;
    {awaddr, araddr, wdata, code_wdata} = '0;
    {ext_pins, periph_flag, flag_clear} = '0;
    wstrb      = 4'hF;
    n_mismatch = 0;
    n_checks   = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_periph;
    t_clear;
    t_trap;
    t_ext;
    test_done;
  end
endmodule
